// file: core/rtc_calendar_alarm.sv
// rtc_calendar_alarm: bcd clock, calendar and maskable alarm with byte register port
// assumes the serial engine presents one register access per cycle and pulses
// read_command once when a serial read command arrives
`timescale 1ns/1ps
module rtc_calendar_alarm #(
  parameter int OSC_DIV = rtc_pkg::OSC_DIV_DEFAULT,
  parameter int OSC_PER_SECOND = rtc_pkg::OSC_PER_SECOND_DEFAULT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire rtc_pkg::reg_req_t reg_req,
  input wire logic read_command,
  output logic [7:0] reg_rdata,
  output logic clock_alarm_flag,
  output logic oscillator_running
);
  import rtc_pkg::*;

  if (OSC_DIV < 2 || OSC_PER_SECOND < 2) begin : g_check
    $error("rtc_calendar_alarm: dividers must be at least 2");
  end

  localparam int DIV_W = $clog2(OSC_DIV);
  localparam int SEC_W = $clog2(OSC_PER_SECOND);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(OSC_PER_SECOND - 1);

  // ----------------------------------------
  // bcd helpers
  // ----------------------------------------
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    logic [7:0] r;
    r = v + 8'h01;
    if (v == last) begin
      r = first;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end
    return r;
  endfunction

  function automatic logic leap_year(input logic [7:0] y);
    // tens even: units 0,4,8; tens odd: units 2,6; year 00 counts as leap
    logic l;
    l = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
             : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    return l;
  endfunction

  function automatic logic [7:0] last_date(input logic [7:0] m, input logic [7:0] y);
    logic [7:0] d;
    case (m)
      8'h02: d = leap_year(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
      default: d = 8'h31;
    endcase
    return d;
  endfunction

  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    return v & m;
  endfunction

  // ----------------------------------------
  // reset synchroniser
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  rtc_time_t live;
  rtc_time_t shadow;
  rtc_time_t next_time;
  logic [7:0] alarm_seconds_match;
  logic [7:0] alarm_minutes_match;
  logic [7:0] alarm_hours_match;
  logic [7:0] alarm_day_or_date_match;
  logic [7:0] control;
  logic oscillator_run;
  logic clock_alarm_enable;
  logic [DIV_W-1:0] osc_count;
  logic [SEC_W-1:0] sub_second;
  logic osc_tick;
  logic second_tick;
  logic tick_done;
  logic alarm_hit;
  logic seconds_written;

  assign oscillator_run = control[BIT_OSCILLATOR_RUN];
  assign clock_alarm_enable = control[BIT_CLOCK_ALARM_ENABLE];
  assign seconds_written = reg_req.write && reg_req.addr == ADDR_SECONDS;

  // ----------------------------------------
  // time base
  // ----------------------------------------
  // the 32 khz rate is an enable from the system clock; halted oscillator freezes it
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      osc_count <= '0;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= 1'b0;
      if (oscillator_run) begin
        if (osc_count == DIV_LAST) begin
          osc_count <= '0;
          osc_tick <= 1'b1;
        end else begin
          osc_count <= osc_count + DIV_W'(1);
        end
      end
    end
  end

  // a seconds write restarts the sub-second count, so the next carry is a full second away
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sub_second <= '0;
      second_tick <= 1'b0;
    end else begin
      second_tick <= 1'b0;
      if (seconds_written) begin
        sub_second <= '0;
      end else if (osc_tick) begin
        if (sub_second == SEC_LAST) begin
          sub_second <= '0;
          second_tick <= 1'b1;
        end else begin
          sub_second <= sub_second + SEC_W'(1);
        end
      end
    end
  end

  // ----------------------------------------
  // calendar advance
  // ----------------------------------------
  always_comb begin
    logic carry;
    logic [4:0] h12;
    logic [7:0] h24;
    logic [7:0] h12_step;
    logic [7:0] h24_step;
    next_time = live;
    carry = 1'b0;
    h12 = live.hours[4:0];
    h24 = {2'b00, live.hours[5:0]};
    h12_step = bcd_step({3'b000, h12}, 8'h12, 8'h01);
    h24_step = bcd_step(h24, 8'h23, 8'h00);
    next_time.seconds = bcd_step(live.seconds, 8'h59, 8'h00);
    if (live.seconds == 8'h59) begin
      next_time.minutes = bcd_step(live.minutes, 8'h59, 8'h00);
      if (live.minutes == 8'h59) begin
        if (live.hours[BIT_HOUR_12]) begin
          next_time.hours[4:0] = (h12 == 5'h12) ? 5'h01 : h12_step[4:0];
          if (h12 == 5'h11) begin
            next_time.hours[BIT_PM] = ~live.hours[BIT_PM];
            carry = live.hours[BIT_PM];
          end
        end else begin
          next_time.hours[5:0] = h24_step[5:0];
          carry = (h24 == 8'h23);
        end
      end
    end
    if (carry) begin
      next_time.weekday = bcd_step(live.weekday, 8'h07, 8'h01);
      next_time.date = bcd_step(live.date, last_date(live.month, live.year), 8'h01);
      if (live.date == last_date(live.month, live.year)) begin
        next_time.month = bcd_step(live.month, 8'h12, 8'h01);
        if (live.month == 8'h12) begin
          next_time.year = bcd_step(live.year, 8'h99, 8'h00);
        end
      end
    end
  end

  // ----------------------------------------
  // time and calendar registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      live <= '0;
    end else if (reg_req.write) begin
      // a write lands immediately and takes precedence over a same-cycle tick
      case (reg_req.addr)
        ADDR_SECONDS: live.seconds <= masked(reg_req.wdata, MASK_SECONDS);
        ADDR_MINUTES: live.minutes <= masked(reg_req.wdata, MASK_MINUTES);
        ADDR_HOURS: live.hours <= masked(reg_req.wdata, MASK_HOURS);
        ADDR_WEEKDAY: live.weekday <= masked(reg_req.wdata, MASK_WEEKDAY);
        ADDR_DATE: live.date <= masked(reg_req.wdata, MASK_DATE);
        ADDR_MONTH: live.month <= masked(reg_req.wdata, MASK_MONTH);
        ADDR_YEAR: live.year <= masked(reg_req.wdata, MASK_YEAR);
        default: begin
          if (second_tick) begin
            live <= next_time;
          end
        end
      endcase
    end else if (second_tick) begin
      live <= next_time;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      shadow <= '0;
    end else if (read_command) begin
      shadow <= live;
    end
  end

  // ----------------------------------------
  // alarm and control registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      alarm_seconds_match <= RESET_BYTE;
      alarm_minutes_match <= RESET_BYTE;
      alarm_hours_match <= RESET_BYTE;
      alarm_day_or_date_match <= RESET_BYTE;
      control <= RESET_BYTE;
    end else if (reg_req.write) begin
      case (reg_req.addr)
        ADDR_ALARM_SECONDS: alarm_seconds_match <= masked(reg_req.wdata, MASK_ALARM);
        ADDR_ALARM_MINUTES: alarm_minutes_match <= masked(reg_req.wdata, MASK_ALARM);
        ADDR_ALARM_HOURS: alarm_hours_match <= masked(reg_req.wdata, MASK_ALARM);
        ADDR_ALARM_DAY: alarm_day_or_date_match <= masked(reg_req.wdata, MASK_ALARM);
        ADDR_CONTROL: control <= masked(reg_req.wdata, MASK_CONTROL);
        default: control <= control;
      endcase
    end
  end

  // ----------------------------------------
  // alarm compare
  // ----------------------------------------
  always_comb begin
    logic sec_ok;
    logic min_ok;
    logic hr_ok;
    logic day_ok;
    logic [7:0] day_src;
    sec_ok = masked(alarm_seconds_match ^ live.seconds, COMPARE_LOW7) == 8'h00;
    min_ok = masked(alarm_minutes_match ^ live.minutes, COMPARE_LOW7) == 8'h00;
    hr_ok = masked(alarm_hours_match ^ live.hours, COMPARE_LOW7) == 8'h00;
    day_src = alarm_day_or_date_match[BIT_DAY_DATE_SELECT] ? live.weekday : live.date;
    day_ok = masked(alarm_day_or_date_match ^ day_src, COMPARE_LOW6) == 8'h00;
    // from seconds upward, each clear mask before the first set one adds one more field that must match
    alarm_hit = alarm_seconds_match[BIT_MASK] ||
                (sec_ok && (alarm_minutes_match[BIT_MASK] ||
                (min_ok && (alarm_hours_match[BIT_MASK] ||
                (hr_ok && (alarm_day_or_date_match[BIT_MASK] || day_ok))))));
  end

  // compare one cycle after the count settles, so the new second is seen
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tick_done <= 1'b0;
    end else begin
      tick_done <= second_tick;
    end
  end

  // set wins over a same-cycle clear so a match is never lost
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clock_alarm_flag <= 1'b0;
    end else if (tick_done && alarm_hit && clock_alarm_enable && oscillator_run) begin
      clock_alarm_flag <= 1'b1;
    end else if (reg_req.write && reg_req.addr == ADDR_STATUS) begin
      clock_alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      oscillator_running <= 1'b0;
    end else begin
      oscillator_running <= oscillator_run;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= RESET_BYTE;
    end else if (reg_req.read) begin
      case (reg_req.addr)
        ADDR_SECONDS: reg_rdata <= shadow.seconds;
        ADDR_MINUTES: reg_rdata <= shadow.minutes;
        ADDR_HOURS: reg_rdata <= shadow.hours;
        ADDR_WEEKDAY: reg_rdata <= shadow.weekday;
        ADDR_DATE: reg_rdata <= shadow.date;
        ADDR_MONTH: reg_rdata <= shadow.month;
        ADDR_YEAR: reg_rdata <= shadow.year;
        ADDR_ALARM_SECONDS: reg_rdata <= alarm_seconds_match;
        ADDR_ALARM_MINUTES: reg_rdata <= alarm_minutes_match;
        ADDR_ALARM_HOURS: reg_rdata <= alarm_hours_match;
        ADDR_ALARM_DAY: reg_rdata <= alarm_day_or_date_match;
        ADDR_CONTROL: reg_rdata <= control;
        ADDR_STATUS: reg_rdata <= 8'(clock_alarm_flag) << BIT_CLOCK_ALARM_FLAG;
        default: reg_rdata <= RESET_BYTE;
      endcase
    end
  end
endmodule

// file: include/rtc_pkg.sv
// rtc_pkg: shared constants, register map and carrier types of the rtc calendar core
// assumes a byte-wide register port driven by the device's serial command engine
//
// Contract
// - battery ramp-up reset clears every time and calendar register to zero
// - bits fixed at zero in time, calendar and alarm registers ignore writes
// - writing a time or calendar register updates the running count at once
// - after a seconds write, no carry into higher counters for one second
// - a read command snapshots time registers; reads of them return the snapshot
// - all time and calendar counters hold and count in bcd
// - hour-format bit 6 set gives 12-hour mode, bit 5 is am/pm
// - hour-format bit clear counts 0 to 23, bits 5:4 as tens
// - weekday advances at midnight, one to seven, wrapping to one
// - february gets 29 days when year is 00 or divisible by four
// - the four alarm registers clear to zero at battery ramp-up
// - alarm seconds, minutes, hours compare bits 6:0 with time registers
// - fourth alarm low six bits compare weekday or date by day/date select
// - mask bits choose per-second, per-minute, hourly or daily alarms
// - all masks clear: weekly or monthly alarm by day/date select
// - an alarm match sets the clock-alarm flag in the status register
// - no clock alarms unless oscillator-run is set
// - clock-alarm flag sets only with clock-alarm enable and a match
// - control bit 1 halts the oscillator when 0, runs it when 1
// - any write to the status register clears all its flags; here an alarm set in the same cycle wins over the write
package rtc_pkg;
  localparam int ADDR_W = 9;
  localparam logic [ADDR_W-1:0] ADDR_SECONDS = 9'h129;
  localparam logic [ADDR_W-1:0] ADDR_MINUTES = 9'h12a;
  localparam logic [ADDR_W-1:0] ADDR_HOURS = 9'h12b;
  localparam logic [ADDR_W-1:0] ADDR_WEEKDAY = 9'h12c;
  localparam logic [ADDR_W-1:0] ADDR_DATE = 9'h12d;
  localparam logic [ADDR_W-1:0] ADDR_MONTH = 9'h12e;
  localparam logic [ADDR_W-1:0] ADDR_YEAR = 9'h12f;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_SECONDS = 9'h130;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_MINUTES = 9'h131;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_HOURS = 9'h132;
  localparam logic [ADDR_W-1:0] ADDR_ALARM_DAY = 9'h133;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 9'h134;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 9'h135;
  // writable bits; the rest are fixed at zero
  localparam logic [7:0] MASK_SECONDS = 8'h7f;
  localparam logic [7:0] MASK_MINUTES = 8'h7f;
  localparam logic [7:0] MASK_HOURS = 8'h7f;
  localparam logic [7:0] MASK_WEEKDAY = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3f;
  localparam logic [7:0] MASK_MONTH = 8'h1f;
  localparam logic [7:0] MASK_YEAR = 8'hff;
  localparam logic [7:0] MASK_ALARM = 8'hff;
  localparam logic [7:0] MASK_CONTROL = 8'h7f;
  localparam logic [7:0] COMPARE_LOW7 = 8'h7f;
  localparam logic [7:0] COMPARE_LOW6 = 8'h3f;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // field positions
  localparam int BIT_MASK = 7;
  localparam int BIT_DAY_DATE_SELECT = 6;
  localparam int BIT_HOUR_12 = 6;
  localparam int BIT_PM = 5;
  localparam int BIT_CLOCK_ALARM_ENABLE = 0;
  localparam int BIT_OSCILLATOR_RUN = 1;
  localparam int BIT_CLOCK_ALARM_FLAG = 2;
  // timing
  localparam longint CLOCK_HZ = 100_000_000;
  localparam longint OSC_HZ = 32_768;
  localparam int OSC_DIV_DEFAULT = int'(CLOCK_HZ / OSC_HZ);
  localparam int OSC_PER_SECOND_DEFAULT = 32_768;

  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] weekday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } rtc_time_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic read;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// file: tb/rtc_calendar_alarm_asserts.sv
// rtc_calendar_alarm_asserts: port-level checks of the rtc calendar core
// assumes it is bound to rtc_calendar_alarm and sees only that module's ports
`timescale 1ns/1ps
module rtc_calendar_alarm_asserts #(
  parameter int OSC_DIV = 2,
  parameter int OSC_PER_SECOND = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire rtc_pkg::reg_req_t reg_req,
  input wire logic read_command,
  input wire logic [7:0] reg_rdata,
  input wire logic clock_alarm_flag,
  input wire logic oscillator_running
);
  import rtc_pkg::*;
  // ----------------------------------------
  // shadow copies of host writes
  // ----------------------------------------
  logic [7:0] ctl;
  logic [7:0] alarm_copy [4];
  wire is_status_wr = reg_req.write && reg_req.addr == ADDR_STATUS;
  wire is_alarm = reg_req.addr inside {[ADDR_ALARM_SECONDS:ADDR_ALARM_DAY]};
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl <= RESET_BYTE;
    end else if (reg_req.write && reg_req.addr == ADDR_CONTROL) begin
      ctl <= reg_req.wdata & MASK_CONTROL;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alarm_copy <= '{default: RESET_BYTE};
    end else if (reg_req.write && is_alarm) begin
      alarm_copy[reg_req.addr[1:0]] <= reg_req.wdata & MASK_ALARM;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_alarm_read;
    reg_req.read && is_alarm;
  endsequence
  sequence s_status_read;
    reg_req.read && reg_req.addr == ADDR_STATUS;
  endsequence
  a_alarm_readback: assert property (s_alarm_read |=>
    reg_rdata == $past(alarm_copy[reg_req.addr[1:0]])) else $error("alarm readback wrong");
  a_flag_needs_enable: assert property ($rose(clock_alarm_flag) |->
    $past(ctl[1:0]) == 2'b11) else $error("alarm flag rose while disabled");
  a_flag_clear_cause: assert property ($fell(clock_alarm_flag) |->
    $past(is_status_wr)) else $error("alarm flag fell without status write");
  a_flag_holds: assert property (clock_alarm_flag && !is_status_wr |=>
    clock_alarm_flag) else $error("alarm flag dropped on its own");
  a_osc_follows: assert property (oscillator_running == $past(ctl[1]))
    else $error("oscillator state differs from control bit");
  a_rdata_holds: assert property (!reg_req.read |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_time_bit7_zero: assert property (reg_req.read &&
    reg_req.addr inside {[ADDR_SECONDS:ADDR_MONTH]} |=> !reg_rdata[7])
    else $error("fixed time bit read as one");
  a_weekday_high_zero: assert property (reg_req.read &&
    reg_req.addr == ADDR_WEEKDAY |=> reg_rdata[7:3] == 5'h0)
    else $error("weekday high bits read as one");
  a_status_readback: assert property (s_status_read |=>
    reg_rdata == {5'h0, $past(clock_alarm_flag), 2'h0}) else $error("status read wrong");
endmodule
bind rtc_calendar_alarm rtc_calendar_alarm_asserts #(.OSC_DIV(OSC_DIV),
  .OSC_PER_SECOND(OSC_PER_SECOND)) u_rtc_calendar_alarm_asserts (.clock(clock),
  .rstn(rstn), .reg_req(reg_req), .read_command(read_command), .reg_rdata(reg_rdata),
  .clock_alarm_flag(clock_alarm_flag), .oscillator_running(oscillator_running));

// file: tb/host_port_model.sv
// host_port_model: behavioural host issuing register accesses to the rtc core
// assumes one access at a time, launched just after a rising clock edge
`timescale 1ns/1ps
module host_port_model (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  output rtc_pkg::reg_req_t reg_req,
  output logic read_command
);
  import rtc_pkg::*;
  initial begin
    reg_req = '0;
    read_command = 1'b0;
  end
  // idle lines show the inverse of the last address so stale values never match
  task automatic write_reg(input logic [ADDR_W-1:0] addr, input logic [7:0] data);
    @(posedge clock);
    reg_req <= '{addr, 1'b1, 1'b0, data};
    @(posedge clock);
    reg_req <= '{~addr, 1'b0, 1'b0, ~data};
    @(negedge clock);
  endtask
  task automatic read_reg(input logic [ADDR_W-1:0] addr, output logic [7:0] data);
    @(posedge clock);
    reg_req <= '{addr, 1'b0, 1'b1, 8'h00};
    @(posedge clock);
    reg_req <= '{~addr, 1'b0, 1'b0, 8'hff};
    @(negedge clock);
    data = reg_rdata;
  endtask
  task automatic snapshot();
    @(posedge clock);
    read_command <= 1'b1;
    @(posedge clock);
    read_command <= 1'b0;
    @(negedge clock);
  endtask
  task automatic set_time(input rtc_time_t t);
    for (int i = 0; i < 7; i++) begin
      write_reg(ADDR_W'(ADDR_SECONDS + i), t[55-8*i -: 8]);
    end
  endtask
  task automatic read_time(output rtc_time_t t);
    logic [7:0] b;
    for (int i = 0; i < 7; i++) begin
      read_reg(ADDR_W'(ADDR_SECONDS + i), b);
      t[55-8*i -: 8] = b;
    end
  endtask
endmodule

// file: tb/tb_rtc_calendar_alarm.sv
// tb_rtc_calendar_alarm: self-checking bench for the rtc calendar core
// assumes host_port_model issues every register access
`timescale 1ns/1ps
module tb_rtc_calendar_alarm;
  import rtc_pkg::*;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] want;
  } row_t;
  row_t rows [10] = '{'{9'h129, 8'hff, 8'h7f}, '{9'h12b, 8'hff, 8'h7f},
    '{9'h12c, 8'hff, 8'h07}, '{9'h12d, 8'hff, 8'h3f}, '{9'h12e, 8'hff, 8'h1f},
    '{9'h12f, 8'hff, 8'hff}, '{9'h133, 8'hff, 8'hff}, '{9'h134, 8'hfc, 8'h7c},
    '{9'h135, 8'hff, 8'h00}, '{9'h128, 8'hff, 8'h00}};
  // pairs of time before and one second after
  rtc_time_t rolls [10] = '{56'h59_5971_0728_0224, 56'h00_0052_0129_0224,
    56'h59_5923_0331_1299, 56'h00_0000_0401_0100, 56'h59_5951_0228_0223,
    56'h00_0072_0228_0223, 56'h59_5923_0528_0223, 56'h00_0000_0601_0323,
    56'h59_5972_0515_0623, 56'h00_0061_0515_0623};
  logic clock = 1'b0;
  logic rstn = 1'b0;
  reg_req_t reg_req;
  logic read_command;
  logic [7:0] reg_rdata;
  logic clock_alarm_flag;
  logic oscillator_running;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] b;
  rtc_time_t t;
  always #5 clock = ~clock;
  rtc_calendar_alarm #(.OSC_DIV(2), .OSC_PER_SECOND(8)) u_rtc_calendar_alarm (
    .clock(clock), .rstn(rstn), .reg_req(reg_req), .read_command(read_command),
    .reg_rdata(reg_rdata), .clock_alarm_flag(clock_alarm_flag),
    .oscillator_running(oscillator_running));
  host_port_model u_host_port_model (.clock(clock), .reg_rdata(reg_rdata),
    .reg_req(reg_req), .read_command(read_command));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    u_host_port_model.write_reg(a, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    u_host_port_model.read_reg(a, d);
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      miscompares++;
      $display("unexpected at %0t: byte %h, wanted %h", $time, got, want);
    end
  endtask
  task automatic check_bit(input logic got, input logic want);
    num_checks++;
    if (got !== want) begin
      miscompares++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, want);
    end
  endtask
  task automatic check_time(input rtc_time_t got, input rtc_time_t want);
    for (int j = 0; j < 7; j++) begin
      check_byte(got[55-8*j -: 8], want[55-8*j -: 8]);
    end
  endtask
  task automatic give_up();
    miscompares++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask
  // bounded: a second is 16 clocks here, a poll 4
  task automatic poll_second();
    for (int k = 0; k < 60; k++) begin
      u_host_port_model.snapshot();
      rd(ADDR_SECONDS, b);
      if (b === 8'h00) return;
    end
    give_up();
  endtask
  task automatic wait_flag();
    for (int k = 0; k < 80; k++) begin
      @(negedge clock);
      if (clock_alarm_flag === 1'b1) return;
    end
    give_up();
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    @(negedge clock);
    check_bit(oscillator_running, 1'b0);
    u_host_port_model.snapshot();
    for (int a = 'h129; a <= 'h133; a++) begin
      rd(a[8:0], b);
      check_byte(b, 8'h00);
    end
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      u_host_port_model.snapshot();
      rd(rows[i].addr, b);
      check_byte(b, rows[i].want);
    end
    for (int i = 0; i < 10; i += 2) begin
      u_host_port_model.set_time(rolls[i]);
      u_host_port_model.snapshot();
      u_host_port_model.read_time(t);
      check_time(t, rolls[i]);
      wr(ADDR_CONTROL, 8'h02);
      poll_second();
      u_host_port_model.read_time(t);
      check_time(t, rolls[i + 1]);
      wr(ADDR_CONTROL, 8'h00);
    end
    wr(ADDR_SECONDS, 8'h45);
    rd(ADDR_SECONDS, b);
    check_byte(b, 8'h00);
    u_host_port_model.snapshot();
    rd(ADDR_SECONDS, b);
    check_byte(b, 8'h45);
    wr(ADDR_ALARM_SECONDS, 8'h80);
    for (int c = 1; c <= 2; c++) begin
      wr(ADDR_CONTROL, c[7:0]);
      repeat (40) @(negedge clock);
      check_bit(clock_alarm_flag, 1'b0);
      check_bit(oscillator_running, c[1]);
    end
    wr(ADDR_CONTROL, 8'h03);
    wait_flag();
    check_bit(clock_alarm_flag, 1'b1);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    check_bit(clock_alarm_flag, 1'b0);
    u_host_port_model.set_time(56'h59_5923_0331_0124);
    for (int a = 0; a < 4; a++) begin
      wr(ADDR_W'(ADDR_ALARM_SECONDS + a), (a == 3) ? 8'h01 : 8'h00);
    end
    wr(ADDR_CONTROL, 8'h03);
    wait_flag();
    check_bit(clock_alarm_flag, 1'b1);
    // weekly form: day/date select set, weekday after the roll is four
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_STATUS, 8'h00);
    u_host_port_model.set_time(56'h59_5923_0331_0124);
    wr(ADDR_ALARM_DAY, 8'h44);
    wr(ADDR_CONTROL, 8'h03);
    wait_flag();
    check_bit(clock_alarm_flag, 1'b1);
    final_report();
  end
endmodule
